/* design/usbwd_pkg.sv */
// usb write dma bridge constants and types
package usbwd_pkg;

   // clock and timeout tick timing
   localparam int CLK_PERIOD_PS = 4000; // 250 MHz master clock
   localparam int TICK_PERIOD_NS = 1000; // one timeout step is 1 us
   localparam int TICK_CYCLES =
      (TICK_PERIOD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [7:0] TICK_LOAD = 8'(TICK_CYCLES - 1);

   // register byte offsets
   localparam logic [11:0] OFF_ISTS = 12'h000; // irq_status_reg
   localparam logic [11:0] OFF_IENB = 12'h004; // irq_enable_reg
   localparam logic [11:0] OFF_SET = 12'h008; // master_setting_reg
   localparam logic [11:0] OFF_START = 12'h00c; // write_start_addr_reg
   localparam logic [11:0] OFF_END = 12'h010; // write_end_addr_reg
   localparam logic [11:0] OFF_CUR = 12'h014; // write_current_addr_reg
   localparam logic [11:0] OFF_TOUT = 12'h018; // write_timeout_reg
   localparam logic [11:0] OFF_PWR = 12'h01c; // power_control_reg
   localparam logic [11:0] OFF_CMD = 12'h020; // core_command_reg

   // master_setting_reg fields
   localparam int SET_EN_BIT = 0; // write_xfer_enable
   localparam int SET_ABORT_BIT = 1; // write_abort_bit
   localparam int SET_RESET_BIT = 2; // write_block_reset_bit

   // write_timeout_reg fields
   localparam int TOUT_W = 16; // preset width
   localparam int TOUT_EN_BIT = 31; // timeout enable

   // power_control_reg fields
   localparam int PWR_SOFT_BIT = 0; // soft_reset_bit
   localparam int PWR_VBUS_BIT = 1; // bus_power_present, read only
   localparam int PWR_NSUSP_BIT = 2; // not suspended, read only
   localparam int PWR_PHY_BIT = 3; // phy sleep request
   localparam int PWR_WAKE_BIT = 4; // wake enable

   // interrupt bit positions
   localparam int IRQ_W = 7;
   localparam int IRQ_END = 0; // write_end_reached_irq
   localparam int IRQ_TOUT = 1; // write_timeout_irq
   localparam int IRQ_UNARM = 2; // write_unarmed_packet_irq
   localparam int IRQ_PWR = 3; // power detect
   localparam int IRQ_SUSP = 4; // suspend / resume
   localparam int IRQ_BRST = 5; // bus reset
   localparam int IRQ_BDONE = 6; // bus reset done

   // reset values
   localparam logic [31:0] ADDR_RST = 32'h0000_0000;
   localparam logic [TOUT_W-1:0] TOUT_RST = 16'h0000;
   localparam logic [IRQ_W-1:0] IRQ_RST = 7'h00;
   localparam logic [7:0] CMD_RST = 8'h00;

   // ahb encodings
   localparam logic [1:0] HTRANS_IDLE = 2'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic [31:0] WORD_STEP = 32'h0000_0004;

   // ahb write master state
   typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} usbwd_state_e;

   // ahb master request carrier
   typedef struct packed {
      logic [1:0] htrans;
      logic [31:0] haddr;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
   } usbwd_ahb_s;

   localparam usbwd_ahb_s AHB_RST = '{htrans: HTRANS_IDLE,
      haddr: ADDR_RST, hwrite: 1'b1, hsize: HSIZE_WORD, hwdata: ADDR_RST};

endpackage : usbwd_pkg

/* design/usbwd_top.sv */
// usb write dma bridge: apb registers, ahb write master, power control
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/10ps
// Functional notes
// RQ1: software sets addresses, then enable
// RQ2: copy endpoint data to memory
// RQ3: end address raises end irq
// RQ4: packet while off raises unarmed irq
// RQ5: timeout flushes buffered word
// RQ6: software presets timeout first
// RQ7: timeout irq, enable cleared, no end
// RQ8: current address shows progress
// RQ9: timeout counts when on, packet reloads
// RQ10: timeout off: end address only
// RQ11: abort stops, then clears enable
// RQ12: software abort sequence order
// RQ13: block reset returns to idle
// RQ14: vbus change gives irq and status
// RQ15: soft reset held until cleared
// RQ16: command passed to the core
// RQ17: bus reset raises two irqs
// RQ18: reinit waits for reset done
// RQ19: vbus loss drives wake line
// RQ20: power events keep transfers going
// RQ21: suspend gives irq and status
// RQ22: phy sleep bit drives phy low
// RQ23: reprogram transfers after resume
// RQ24: direct endpoint path first
// RQ25: status ignores mask, mask gates line
// RQ26: wake line apart from irq line
module usbwd_top
   import usbwd_pkg::*;
(
   // clock and reset
   input wire logic MCLK,
   input wire logic RST_N,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // endpoint fifo stream
   input wire logic EP_VALID,
   input wire logic [31:0] EP_DATA,
   input wire logic EP_PKT_END,
   output logic EP_READY,
   // ahb write master
   output logic [1:0] HTRANS,
   output logic [31:0] HADDR,
   output logic HWRITE,
   output logic [2:0] HSIZE,
   output logic [31:0] HWDATA,
   input wire logic HREADY,
   // device core and phy
   input wire logic VBUS_IN,
   input wire logic CORE_SUSPEND_N,
   input wire logic CORE_BUS_RESET,
   output logic SOFT_RESET_N,
   output logic PHY_SLEEP_N,
   output logic CORE_CMD_VALID,
   output logic [7:0] CORE_CMD,
   // interrupt lines
   output logic USB_IRQ,
   output logic USB_WAKE_N
);

   // apb write to this offset completes
   function automatic logic wr_hit(input logic acc,
      input logic [11:0] addr, input logic [11:0] off);
      wr_hit = acc && (addr == off);
   endfunction : wr_hit

   // apb state
   logic pready_reg, pready_next;
   logic [31:0] prdata_reg, prdata_next;
   logic perr_reg, perr_next;
   logic wr_acc; // write taking effect this edge

   // transfer configuration
   logic [31:0] sadr_reg, sadr_next; // write_start_addr_reg
   logic [31:0] eadr_reg, eadr_next; // write_end_addr_reg
   logic [31:0] cur_reg, cur_next; // write_current_addr_reg
   logic [TOUT_W-1:0] pre_reg, pre_next; // timeout preset
   logic ten_reg, ten_next; // timeout enable

   // transfer state
   logic en_reg, en_next; // write_xfer_enable
   logic ab_reg, ab_next; // abort pending
   logic [31:0] buf_reg, buf_next; // one-word holding buffer
   logic full_reg, full_next;
   logic ep_rdy_reg, ep_rdy_next;
   usbwd_state_e st_reg, st_next;
   usbwd_ahb_s ahb_reg, ahb_next;
   logic [TOUT_W-1:0] cnt_reg, cnt_next; // timeout down counter
   logic hit_reg, hit_next; // timeout seen, flushing
   logic [7:0] tick_reg, tick_next; // 1 us divider
   logic tick;

   // events from the transfer logic
   logic ev_end, ev_tout, ev_unarm;

   // power and interrupt state
   logic vbus_reg, vbus_next;
   logic susp_n_reg, susp_n_next;
   logic brst_reg, brst_next;
   logic soft_reg, soft_next;
   logic phy_reg, phy_next;
   logic wake_en_reg, wake_en_next;
   logic wake_n_reg, wake_n_next;
   logic cmd_v_reg, cmd_v_next;
   logic [7:0] cmd_reg, cmd_next;
   logic [IRQ_W-1:0] ists_reg, ists_next;
   logic [IRQ_W-1:0] ienb_reg, ienb_next;
   logic [IRQ_W-1:0] irq_set, irq_clr;
   logic irq_reg, irq_next;

   // write commits only on the edge that samples pready high
   assign wr_acc = PSEL && PENABLE && PWRITE && pready_reg;

   // transfer engine next state
   always_comb begin
      sadr_next = sadr_reg;
      eadr_next = eadr_reg;
      cur_next = cur_reg;
      pre_next = pre_reg;
      ten_next = ten_reg;
      en_next = en_reg;
      ab_next = ab_reg;
      buf_next = buf_reg;
      full_next = full_reg;
      st_next = st_reg;
      ahb_next = ahb_reg;
      cnt_next = cnt_reg;
      hit_next = hit_reg;
      ev_end = 1'b0;
      ev_tout = 1'b0;
      ev_unarm = 1'b0;
      // free running step divider
      tick = (tick_reg == 8'h00);
      tick_next = tick ? TICK_LOAD : tick_reg - 8'h01;
      // configuration writes
      if (wr_hit(wr_acc, PADDR, OFF_START)) begin
         sadr_next = PWDATA;
      end
      if (wr_hit(wr_acc, PADDR, OFF_END)) begin
         eadr_next = PWDATA;
      end
      if (wr_hit(wr_acc, PADDR, OFF_TOUT)) begin
         pre_next = PWDATA[TOUT_W-1:0]; // RQ6
         ten_next = PWDATA[TOUT_EN_BIT]; // RQ10
      end
      // accept a word from the endpoint
      if (EP_VALID && ep_rdy_reg) begin
         buf_next = EP_DATA; // RQ2
         full_next = 1'b1;
      end
      // packet reloads timeout or flags stray
      if (EP_PKT_END) begin
         if (en_reg) begin
            cnt_next = pre_reg; // RQ9
         end else begin
            ev_unarm = 1'b1; // RQ4
         end
      end else if (en_reg && ten_reg && !hit_reg) begin
         if (cnt_reg == TOUT_RST) begin
            hit_next = 1'b1; // RQ7
         end else if (tick) begin
            cnt_next = cnt_reg - 16'h0001; // RQ9
         end
      end
      // ahb single word write master
      case (st_reg)
         ST_IDLE: begin
            // word held: address phase
            if (full_reg) begin
               ahb_next.htrans = HTRANS_NONSEQ; // RQ2
               ahb_next.haddr = cur_reg;
               ahb_next.hwdata = buf_reg;
               st_next = ST_ADDR;
            end
         end
         ST_ADDR: begin
            // address taken, data phase follows
            if (HREADY) begin
               ahb_next.htrans = HTRANS_IDLE;
               st_next = ST_DATA;
            end
         end
         ST_DATA: begin
            // word landed: step address
            if (HREADY) begin
               full_next = 1'b0;
               st_next = ST_IDLE;
               cur_next = cur_reg + WORD_STEP; // RQ8
               if (en_reg && !hit_reg && cur_reg == eadr_reg) begin
                  ev_end = 1'b1; // RQ3
                  en_next = 1'b0;
               end
            end
         end
         default: begin
            st_next = ST_IDLE;
            ahb_next = AHB_RST;
         end
      endcase
      // timeout ends once buffer is out
      if (en_reg && hit_reg && !full_reg && st_reg == ST_IDLE) begin
         ev_tout = 1'b1; // RQ5
         en_next = 1'b0; // RQ7
         hit_next = 1'b0;
      end
      // abort waits for idle bus: no cut beat
      if (ab_reg && st_reg == ST_IDLE) begin
         en_next = 1'b0; // RQ11
         ab_next = 1'b0;
         full_next = 1'b0;
         st_next = ST_IDLE;
         ahb_next = AHB_RST;
      end
      // software control of the transfer
      if (wr_hit(wr_acc, PADDR, OFF_SET)) begin
         if (PWDATA[SET_EN_BIT] && !en_reg) begin
            en_next = 1'b1; // RQ1
            cur_next = sadr_reg;
            cnt_next = pre_reg;
            hit_next = 1'b0;
         end
         if (PWDATA[SET_ABORT_BIT] && en_reg) begin
            ab_next = 1'b1; // RQ11
         end
      end
      // block or soft reset: initial state
      if ((wr_hit(wr_acc, PADDR, OFF_SET) && PWDATA[SET_RESET_BIT])
         || soft_reg) begin // RQ20
         en_next = 1'b0; // RQ13
         ab_next = 1'b0;
         full_next = 1'b0;
         hit_next = 1'b0;
         cnt_next = TOUT_RST;
         cur_next = ADDR_RST;
         st_next = ST_IDLE;
         ahb_next = AHB_RST;
      end
      // intake only while armed and empty
      ep_rdy_next = en_next && !full_next && !hit_next && !ab_next;
   end

   // transfer engine registers
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         sadr_reg <= ADDR_RST;
         eadr_reg <= ADDR_RST;
         cur_reg <= ADDR_RST;
         pre_reg <= TOUT_RST;
         ten_reg <= 1'b0;
         en_reg <= 1'b0;
         ab_reg <= 1'b0;
         buf_reg <= ADDR_RST;
         full_reg <= 1'b0;
         ep_rdy_reg <= 1'b0;
         st_reg <= ST_IDLE;
         ahb_reg <= AHB_RST;
         cnt_reg <= TOUT_RST;
         hit_reg <= 1'b0;
         tick_reg <= TICK_LOAD;
      end else begin
         sadr_reg <= sadr_next;
         eadr_reg <= eadr_next;
         cur_reg <= cur_next;
         pre_reg <= pre_next;
         ten_reg <= ten_next;
         en_reg <= en_next;
         ab_reg <= ab_next;
         buf_reg <= buf_next;
         full_reg <= full_next;
         ep_rdy_reg <= ep_rdy_next;
         st_reg <= st_next;
         ahb_reg <= ahb_next;
         cnt_reg <= cnt_next;
         hit_reg <= hit_next;
         tick_reg <= tick_next;
      end
   end

   // power, interrupt and apb next state
   always_comb begin
      vbus_next = VBUS_IN;
      susp_n_next = CORE_SUSPEND_N;
      brst_next = CORE_BUS_RESET;
      soft_next = soft_reg;
      phy_next = phy_reg;
      wake_en_next = wake_en_reg;
      ienb_next = ienb_reg;
      cmd_next = cmd_reg;
      cmd_v_next = 1'b0;
      // power writes; soft reset stays
      if (wr_hit(wr_acc, PADDR, OFF_PWR)) begin
         soft_next = PWDATA[PWR_SOFT_BIT]; // RQ15
         phy_next = PWDATA[PWR_PHY_BIT]; // RQ22
         wake_en_next = PWDATA[PWR_WAKE_BIT];
      end
      // bus resume wakes the phy
      if (CORE_SUSPEND_N && !susp_n_reg) begin
         phy_next = 1'b0; // RQ22
      end
      // commands pass straight to the core
      if (wr_hit(wr_acc, PADDR, OFF_CMD)) begin
         cmd_v_next = 1'b1; // RQ16
         cmd_next = PWDATA[7:0];
      end
      // wake while enabled and not suspended, or on loss of bus power
      wake_n_next = !((wake_en_next && susp_n_next) || !vbus_next); // RQ19
      // interrupt sources
      irq_set = IRQ_RST;
      irq_set[IRQ_END] = ev_end; // RQ3
      irq_set[IRQ_TOUT] = ev_tout; // RQ7
      irq_set[IRQ_UNARM] = ev_unarm; // RQ4
      irq_set[IRQ_PWR] = (VBUS_IN != vbus_reg); // RQ14
      irq_set[IRQ_SUSP] = (CORE_SUSPEND_N != susp_n_reg); // RQ21
      irq_set[IRQ_BRST] = CORE_BUS_RESET && !brst_reg; // RQ17
      irq_set[IRQ_BDONE] = !CORE_BUS_RESET && brst_reg; // RQ17
      irq_clr = IRQ_RST;
      if (wr_hit(wr_acc, PADDR, OFF_ISTS)) begin
         irq_clr = PWDATA[IRQ_W-1:0];
      end
      if (wr_hit(wr_acc, PADDR, OFF_IENB)) begin
         ienb_next = PWDATA[IRQ_W-1:0];
      end
      // a set in the clearing cycle survives the clear
      ists_next = (ists_reg & ~irq_clr) | irq_set; // RQ25
      irq_next = |(ists_next & ienb_next); // RQ25
      // one wait state on every access
      pready_next = PSEL && PENABLE && !pready_reg;
      prdata_next = 32'h0000_0000;
      perr_next = 1'b0;
      if (pready_next && !PWRITE) begin
         case (PADDR)
            OFF_ISTS: prdata_next[IRQ_W-1:0] = ists_reg;
            OFF_IENB: prdata_next[IRQ_W-1:0] = ienb_reg;
            OFF_SET: begin
               prdata_next[SET_EN_BIT] = en_reg; // RQ11
               prdata_next[SET_ABORT_BIT] = ab_reg;
            end
            OFF_START: prdata_next = sadr_reg;
            OFF_END: prdata_next = eadr_reg;
            OFF_CUR: prdata_next = cur_reg; // RQ8
            OFF_TOUT: begin
               prdata_next[TOUT_W-1:0] = pre_reg;
               prdata_next[TOUT_EN_BIT] = ten_reg;
            end
            OFF_PWR: begin
               prdata_next[PWR_SOFT_BIT] = soft_reg;
               prdata_next[PWR_VBUS_BIT] = vbus_reg; // RQ14
               prdata_next[PWR_NSUSP_BIT] = susp_n_reg; // RQ21
               prdata_next[PWR_PHY_BIT] = phy_reg;
               prdata_next[PWR_WAKE_BIT] = wake_en_reg;
            end
            OFF_CMD: prdata_next[7:0] = cmd_reg;
            default: perr_next = 1'b1;
         endcase
      end else if (pready_next) begin
         case (PADDR)
            OFF_ISTS, OFF_IENB, OFF_SET, OFF_START, OFF_END,
            OFF_CUR, OFF_TOUT, OFF_PWR, OFF_CMD: perr_next = 1'b0;
            default: perr_next = 1'b1;
         endcase
      end
   end

   // power, interrupt and apb registers
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         vbus_reg <= 1'b0;
         susp_n_reg <= 1'b1;
         brst_reg <= 1'b0;
         soft_reg <= 1'b0;
         phy_reg <= 1'b0;
         wake_en_reg <= 1'b0;
         wake_n_reg <= 1'b1;
         cmd_v_reg <= 1'b0;
         cmd_reg <= CMD_RST;
         ists_reg <= IRQ_RST;
         ienb_reg <= IRQ_RST;
         irq_reg <= 1'b0;
         pready_reg <= 1'b0;
         prdata_reg <= ADDR_RST;
         perr_reg <= 1'b0;
      end else begin
         vbus_reg <= vbus_next;
         susp_n_reg <= susp_n_next;
         brst_reg <= brst_next;
         soft_reg <= soft_next;
         phy_reg <= phy_next;
         wake_en_reg <= wake_en_next;
         wake_n_reg <= wake_n_next;
         cmd_v_reg <= cmd_v_next;
         cmd_reg <= cmd_next;
         ists_reg <= ists_next;
         ienb_reg <= ienb_next;
         irq_reg <= irq_next;
         pready_reg <= pready_next;
         prdata_reg <= prdata_next;
         perr_reg <= perr_next;
      end
   end

   // outputs, all straight from flip-flops
   assign PRDATA = prdata_reg;
   assign PREADY = pready_reg;
   assign PSLVERR = perr_reg;
   assign EP_READY = ep_rdy_reg;
   assign HTRANS = ahb_reg.htrans;
   assign HADDR = ahb_reg.haddr;
   assign HWRITE = ahb_reg.hwrite;
   assign HSIZE = ahb_reg.hsize;
   assign HWDATA = ahb_reg.hwdata;
   assign SOFT_RESET_N = !soft_reg; // RQ15
   assign PHY_SLEEP_N = !phy_reg; // RQ22
   assign CORE_CMD_VALID = cmd_v_reg;
   assign CORE_CMD = cmd_reg;
   assign USB_IRQ = irq_reg;
   assign USB_WAKE_N = wake_n_reg; // RQ26

endmodule : usbwd_top

/* testbench/usbwd_monitor.sv */
// port checker of the usb write dma bridge
`timescale 1ns/10ps
module usbwd_monitor
   import usbwd_pkg::*;
(
   // clock, reset and apb
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic PREADY,
   // endpoint stream and ahb
   input wire logic EP_VALID,
   input wire logic [31:0] EP_DATA,
   input wire logic EP_READY,
   input wire logic [1:0] HTRANS,
   input wire logic [31:0] HADDR,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   // power and interrupt pins
   input wire logic VBUS_IN,
   input wire logic CORE_SUSPEND_N,
   input wire logic SOFT_RESET_N,
   input wire logic PHY_SLEEP_N,
   input wire logic CORE_CMD_VALID,
   input wire logic [7:0] CORE_CMD,
   input wire logic USB_IRQ,
   input wire logic USB_WAKE_N
);
   // committed apb write
   logic wr;
   assign wr = PSEL && PENABLE && PREADY && PWRITE;
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);

   property p_apb_wait;
      PSEL && !PENABLE |=> !PREADY ##1 PREADY;
   endproperty
   a_apb_wait: assert property (p_apb_wait)
      else $error("apb wait");
   property p_ep_take;
      EP_VALID && EP_READY |=> !EP_READY ##1 HTRANS == HTRANS_NONSEQ
         && HWDATA == $past(EP_DATA, 2);
   endproperty
   a_ep_take: assert property (p_ep_take)
      else $error("ep to ahb");
   property p_ahb_hold;
      HTRANS == HTRANS_NONSEQ && !HREADY |=> HTRANS == HTRANS_NONSEQ
         && $stable(HADDR) && $stable(HWDATA);
   endproperty
   a_ahb_hold: assert property (p_ahb_hold)
      else $error("ahb hold");
   property p_soft_set;
      wr && PADDR == OFF_PWR |=> SOFT_RESET_N == !$past(PWDATA[PWR_SOFT_BIT]);
   endproperty
   a_soft_set: assert property (p_soft_set)
      else $error("soft set");
   property p_soft_hold;
      !SOFT_RESET_N && !(wr && PADDR == OFF_PWR) |=> !SOFT_RESET_N;
   endproperty
   a_soft_hold: assert property (p_soft_hold)
      else $error("soft hold");
   property p_cmd;
      wr && PADDR == OFF_CMD |=> CORE_CMD_VALID
         && CORE_CMD == $past(PWDATA[7:0]);
   endproperty
   a_cmd: assert property (p_cmd)
      else $error("core cmd");
   property p_wake;
      !VBUS_IN |=> !USB_WAKE_N;
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake");
   property p_phy;
      wr && PADDR == OFF_PWR && PWDATA[PWR_PHY_BIT]
         && !$rose(CORE_SUSPEND_N) |=> !PHY_SLEEP_N;
   endproperty
   a_phy: assert property (p_phy)
      else $error("phy sleep");
   property p_mask;
      wr && PADDR == OFF_IENB && PWDATA[IRQ_W-1:0] == '0 |=> ##1 !USB_IRQ;
   endproperty
   a_mask: assert property (p_mask)
      else $error("irq mask");
   property p_abort;
      wr && PADDR == OFF_SET && PWDATA[SET_ABORT_BIT]
         |-> ##[1:40] !EP_READY [*8];
   endproperty
   a_abort: assert property (p_abort)
      else $error("abort");
endmodule : usbwd_monitor

bind usbwd_top usbwd_monitor usbwd_monitor_i (.*);

/* testbench/usbwd_mem.sv */
// ahb memory model
`timescale 1ns/10ps
module usbwd_mem
   import usbwd_pkg::*;
(
   // clock, reset, stall request
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic slow,
   // ahb slave side
   input wire logic [1:0] HTRANS,
   input wire logic [31:0] HADDR,
   input wire logic [31:0] HWDATA,
   output logic HREADY = 1'b1
);
   logic [31:0] mem [bit [31:0]]; // written words
   logic [31:0] pend_addr; // pending address
   logic pend = 1'b0; // data phase due
   logic [1:0] cnt = 2'h0; // stall pattern counter
   // slow: ready one cycle in four
   always @(posedge MCLK) begin
      if (!RST_N) begin
         pend <= 1'b0;
         HREADY <= 1'b1;
      end else begin
         cnt <= cnt + 2'h1;
         HREADY <= !slow || cnt == 2'h3;
         if (HREADY && pend) begin
            mem[pend_addr] = HWDATA;
         end
         if (HREADY) begin
            pend <= HTRANS == HTRANS_NONSEQ;
            pend_addr <= HADDR;
         end
      end
   end
endmodule : usbwd_mem

/* testbench/tb.sv */
// self-checking bench of the usb write dma bridge
`timescale 1ns/10ps
module tb;
   import usbwd_pkg::*;
   // stimulus
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, ep_data = 32'h0;
   logic ep_valid = 1'b0, ep_pkt_end = 1'b0, slow = 1'b0;
   logic vbus_in = 1'b1, core_suspend_n = 1'b1, core_bus_reset = 1'b0;
   // design outputs
   logic [31:0] prdata, haddr, hwdata;
   logic pready, pslverr, ep_ready, hwrite, hready;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic soft_reset_n, phy_sleep_n, core_cmd_valid, usb_irq, usb_wake_n;
   logic [7:0] core_cmd;
   // read capture, seed, expected words
   logic [31:0] rd, seed = 32'h2d92551b;
   logic slverr;
   logic [31:0] exp_q[$];
   int errors = 0, tests_run = 0;

   usbwd_top usbwd_top_i (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .EP_VALID(ep_valid), .EP_DATA(ep_data), .EP_PKT_END(ep_pkt_end),
      .EP_READY(ep_ready), .HTRANS(htrans), .HADDR(haddr), .HWRITE(hwrite),
      .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .VBUS_IN(vbus_in),
      .CORE_SUSPEND_N(core_suspend_n), .CORE_BUS_RESET(core_bus_reset),
      .SOFT_RESET_N(soft_reset_n), .PHY_SLEEP_N(phy_sleep_n),
      .CORE_CMD_VALID(core_cmd_valid), .CORE_CMD(core_cmd),
      .USB_IRQ(usb_irq), .USB_WAKE_N(usb_wake_n));
   usbwd_mem usbwd_mem_i (.MCLK(mclk), .RST_N(rst_n), .slow(slow),
      .HTRANS(htrans), .HADDR(haddr), .HWDATA(hwdata), .HREADY(hready));

   initial begin
      forever #2 mclk = ~mclk;
   end
   // xorshift words
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic conclude();
      $display("comparisons %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : conclude
   // one bounded apb transfer
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         errors++;
         conclude();
      end
      rd = prdata;
      slverr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdc(input logic [11:0] a, input logic [31:0] e,
      input string n);
      apb(1'b0, a, 32'h0);
      chk(n, e, rd);
   endtask : rdc
   // poll enable clear
   task automatic wait_idle();
      for (int n = 0; n < 800; n++) begin
         apb(1'b0, OFF_SET, 32'h0);
         if (rd[SET_EN_BIT] === 1'b0) return;
      end
      errors++;
      conclude();
   endtask : wait_idle
   task automatic launch(input logic [31:0] s, e, t);
      apb(1'b1, OFF_TOUT, t);
      apb(1'b1, OFF_START, s);
      apb(1'b1, OFF_END, e);
      apb(1'b1, OFF_SET, 32'h1);
   endtask : launch
   // hand one random word over
   task automatic send();
      logic [31:0] w;
      int n;
      w = xs();
      exp_q.push_back(w);
      @(posedge mclk);
      ep_valid <= 1'b1;
      ep_data <= w;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (ep_ready !== 1'b1 && n < 60);
      if (ep_ready !== 1'b1) begin
         errors++;
         conclude();
      end
      ep_valid <= 1'b0;
      ep_data <= ~w;
   endtask : send
   task automatic pkt();
      @(posedge mclk);
      ep_pkt_end <= 1'b1;
      @(posedge mclk);
      ep_pkt_end <= 1'b0;
   endtask : pkt
   task automatic memchk(input logic [31:0] b);
      foreach (exp_q[i]) chk("mem", exp_q[i], usbwd_mem_i.mem[b + 4 * i]);
      exp_q.delete();
   endtask : memchk

   initial begin
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      rdc(OFF_IENB, 32'h0, "irq enable");
      apb(1'b0, 12'h100, 32'h0);
      chk("unmapped", 32'h1, {31'h0, slverr});
      chk("unmapped rd", 32'h0, rd);
      apb(1'b1, OFF_ISTS, 32'h7f);
      // stalled memory, four words to end
      slow <= 1'b1;
      launch(32'h1000, 32'h100c, 32'h0);
      repeat (4) send();
      chk("ahb ctl", {1'b1, HSIZE_WORD}, {hwrite, hsize});
      wait_idle();
      memchk(32'h1000);
      rdc(OFF_CUR, 32'h1010, "cur addr");
      rdc(OFF_ISTS, 32'h1, "end status");
      apb(1'b1, OFF_ISTS, 32'h7f);
      // stray packet, masked then not
      pkt();
      repeat (4) @(posedge mclk);
      chk("irq masked", 32'h0, usb_irq);
      apb(1'b1, OFF_IENB, 32'h1 << IRQ_UNARM);
      repeat (3) @(posedge mclk);
      chk("irq line", 32'h1, usb_irq);
      rdc(OFF_ISTS, 32'h1 << IRQ_UNARM, "unarmed");
      apb(1'b1, OFF_ISTS, 32'h7f);
      apb(1'b1, OFF_IENB, 32'h0);
      // timeout with one reload
      slow <= 1'b0;
      launch(32'h2000, 32'h20fc, 32'h8000_0004);
      repeat (2) send();
      repeat (600) @(posedge mclk);
      pkt();
      repeat (600) @(posedge mclk);
      rdc(OFF_SET, 32'h1, "still on");
      wait_idle();
      rdc(OFF_ISTS, 32'h1 << IRQ_TOUT, "timeout");
      rdc(OFF_CUR, 32'h2008, "cur addr");
      memchk(32'h2000);
      apb(1'b1, OFF_ISTS, 32'h7f);
      // abort, block reset, relaunch
      launch(32'h3000, 32'h30fc, 32'h0);
      send();
      repeat (8) @(posedge mclk);
      apb(1'b1, OFF_CMD, 32'h1);
      apb(1'b1, OFF_SET, 32'h2);
      wait_idle();
      rdc(OFF_CUR, 32'h3004, "abort addr");
      memchk(32'h3000);
      apb(1'b1, OFF_SET, 32'h4);
      apb(1'b1, OFF_CMD, 32'h2);
      apb(1'b1, OFF_CMD, 32'h3);
      launch(32'h4000, 32'h4000, 32'h0);
      send();
      wait_idle();
      memchk(32'h4000);
      rdc(OFF_ISTS, 32'h1, "end status");
      apb(1'b1, OFF_ISTS, 32'h7f);
      // power events and soft reset
      vbus_in <= 1'b0;
      core_suspend_n <= 1'b0;
      repeat (4) @(posedge mclk);
      chk("wake", 32'h0, usb_wake_n);
      rdc(OFF_PWR, 32'h0, "power reg");
      apb(1'b1, OFF_PWR, 32'h1 << PWR_PHY_BIT);
      repeat (2) @(posedge mclk);
      chk("phy sleep", 32'h0, phy_sleep_n);
      core_suspend_n <= 1'b1;
      core_bus_reset <= 1'b1;
      repeat (4) @(posedge mclk);
      core_bus_reset <= 1'b0;
      vbus_in <= 1'b1;
      repeat (4) @(posedge mclk);
      chk("phy wake", 32'h1, phy_sleep_n);
      rdc(OFF_ISTS, 32'h78, "power status");
      rdc(OFF_PWR, 32'h6, "power reg");
      apb(1'b1, OFF_PWR, 32'h1);
      repeat (20) @(posedge mclk);
      chk("soft reset", 32'h0, soft_reset_n);
      apb(1'b1, OFF_PWR, 32'h0);
      repeat (2) @(posedge mclk);
      chk("soft release", 32'h1, soft_reset_n);
      conclude();
   end
endmodule : tb
